//--- rtl/hbp_pkg.sv
package hbp_pkg;
  // bus widths
  localparam int DATA_W = 64; // full data path, two 32-bit halves
  localparam int HALF_W = 32; // one half carries four byte lanes
  localparam int LANES = 8; // byte lanes 0..7
  localparam int ADDR_W = 32; // address bus
  localparam int SIZE_W = 3; // transfer size code width
  localparam int TYPE_W = 5; // transfer type code width
  // transfer size codes: 0 is an eight-byte move, 1..7 count bytes
  localparam logic [2:0] SIZE_8B = 3'h0;
  localparam logic [2:0] SIZE_1B = 3'h1;
  localparam logic [2:0] SIZE_4B = 3'h4;
  // transfer type codes used by the bridge
  localparam logic [4:0] TT_WRITE = 5'h02; // write with flush
  localparam logic [4:0] TT_READ = 5'h0a; // read
  localparam logic [4:0] TT_SNOOP_RD = 5'h0a; // snoop broadcast, read
  localparam logic [4:0] TT_SNOOP_WR = 5'h06; // snoop broadcast, kill
  localparam logic [4:0] TT_GFX_RD = 5'h16; // graphics read (unsupported)
  localparam logic [4:0] TT_GFX_WR = 5'h17; // graphics write (unsupported)
  // beats of a burst and reset values
  localparam logic [1:0] BURST_LAST = 2'h3; // four beats per burst
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic ERR_EN_RST = 1'b1; // error acknowledge enabled
endpackage : hbp_pkg

//--- rtl/hbp_bus_if.sv
`timescale 1ns/1ns
// shared processor-side bus; each agent contributes output plus enable
interface hbp_bus_if;
  import hbp_pkg::*;
  // data bus, both halves, driven by device or by far end
  logic [HALF_W-1:0] dev_data_high_half;
  logic [HALF_W-1:0] dev_data_low_half;
  logic dev_data_oe;
  logic [HALF_W-1:0] far_data_high_half;
  logic [HALF_W-1:0] far_data_low_half;
  logic far_data_oe;
  // address tenure signals from either master
  logic dev_transfer_start_strobe;
  logic far_transfer_start_strobe;
  logic [ADDR_W-1:0] dev_addr;
  logic [ADDR_W-1:0] far_addr;
  logic [SIZE_W-1:0] dev_transfer_size_code;
  logic [SIZE_W-1:0] far_transfer_size_code;
  logic [TYPE_W-1:0] dev_transfer_type_code;
  logic [TYPE_W-1:0] far_transfer_type_code;
  logic dev_burst_flag;
  logic far_burst_flag;
  logic dev_global_flag;
  logic dev_global_oe;
  logic far_global_flag;
  logic far_global_oe;
  logic dev_write_through_flag;
  logic dev_write_through_oe;
  logic far_write_through_flag;
  logic far_write_through_oe;
  logic dev_attr_oe; // device owns address and attributes
  logic far_attr_oe;
  // data tenure and status
  logic dev_beat_ack;
  logic dev_beat_ack_oe;
  logic far_beat_ack;
  logic far_beat_ack_oe;
  logic transfer_error_ack;
  logic fatal_error_alert;
  logic local_slave_claim;
  logic ext_addr_start;

  modport dev (
    output dev_data_high_half, dev_data_low_half, dev_data_oe,
    output dev_transfer_start_strobe, dev_addr, dev_transfer_size_code,
    output dev_transfer_type_code, dev_burst_flag, dev_attr_oe,
    output dev_global_flag, dev_global_oe,
    output dev_write_through_flag, dev_write_through_oe,
    output dev_beat_ack, dev_beat_ack_oe,
    output transfer_error_ack, fatal_error_alert,
    input far_data_high_half, far_data_low_half, far_data_oe,
    input far_transfer_start_strobe, far_addr, far_transfer_size_code,
    input far_transfer_type_code, far_burst_flag, far_attr_oe,
    input far_global_flag, far_global_oe,
    input far_write_through_flag, far_write_through_oe,
    input far_beat_ack, far_beat_ack_oe,
    input local_slave_claim, ext_addr_start
  );

  modport far (
    output far_data_high_half, far_data_low_half, far_data_oe,
    output far_transfer_start_strobe, far_addr, far_transfer_size_code,
    output far_transfer_type_code, far_burst_flag, far_attr_oe,
    output far_global_flag, far_global_oe,
    output far_write_through_flag, far_write_through_oe,
    output far_beat_ack, far_beat_ack_oe,
    output local_slave_claim, ext_addr_start,
    input dev_data_high_half, dev_data_low_half, dev_data_oe,
    input dev_transfer_start_strobe, dev_addr, dev_transfer_size_code,
    input dev_transfer_type_code, dev_burst_flag, dev_attr_oe,
    input dev_global_flag, dev_global_oe,
    input dev_write_through_flag, dev_write_through_oe,
    input dev_beat_ack, dev_beat_ack_oe,
    input transfer_error_ack, fatal_error_alert
  );
endinterface : hbp_bus_if

//--- rtl/hbp_dev_port.sv
`timescale 1ns/1ns
// Contract
// [R1] data splits high lanes 0-3, low 4-7
// [R2] drive data only when sourcing it
// [R3] global flag two-way, demands coherency
// [R4] claimed transfers: slave acks, device silent
// [R5] fatal error raises machine check alert
// [R6] device acks beats, last ends tenure
// [R7] L2 or slave acks its own beats
// [R8] burst flag selects burst or single
// [R9] error ack ends transaction at once
// [R10] unsupported transfers raise error ack
// [R11] device starts only snoop broadcasts
// [R12] master starts with valid attributes, captured
// [R13] three-bit size code per transfer
// [R14] five-bit type code per transfer
// [R15] write-through flag two-way, honoured
// [R16] extended start raises error ack
// [R17] enable bit gates all error acks
module hbp_dev_port (
  input wire logic i_clk,
  input wire logic i_rst_b,
  hbp_bus_if.dev bus,
  input wire logic i_err_ack_en,
  input wire logic i_fatal_err,
  input wire logic i_snoop_req,
  input wire logic [hbp_pkg::ADDR_W-1:0] i_snoop_addr,
  input wire logic i_snoop_wr,
  input wire logic [hbp_pkg::DATA_W-1:0] i_rd_data,
  output logic o_snoop_busy,
  output logic o_req_valid,
  output logic [hbp_pkg::ADDR_W-1:0] o_req_addr,
  output logic [hbp_pkg::SIZE_W-1:0] o_req_size,
  output logic [hbp_pkg::TYPE_W-1:0] o_req_type,
  output logic o_req_burst,
  output logic o_req_global,
  output logic o_req_wt,
  output logic o_wr_valid,
  output logic [hbp_pkg::DATA_W-1:0] o_wr_data,
  output logic o_err
);
  import hbp_pkg::*;

  typedef enum logic [3:0] {
    HBP_IDLE = 4'h1, // waiting for a transfer start
    HBP_DATA = 4'h2, // device answers beats
    HBP_CLAIM = 4'h4, // local slave answers, device watches
    HBP_SNOOP = 4'h8 // device drives a snoop address for one cycle
  } hbp_state_t;

  hbp_state_t state_r;
  logic [1:0] beat_r; // beat count within a burst
  logic burst_r; // captured burst flag
  logic write_r; // captured direction
  logic err_r; // registered error acknowledge
  logic ack_r; // registered beat acknowledge
  logic mcp_r; // machine check level
  logic [ADDR_W-1:0] snoop_addr_r;
  logic snoop_wr_r;
  logic unsupported; // graphics transfer types
  logic far_last; // far-end ack that closes a claimed tenure

  // fault and extended-start inputs come from other agents on this clock
  assign unsupported = bus.far_transfer_type_code == TT_GFX_RD ||
    bus.far_transfer_type_code == TT_GFX_WR;
  assign far_last = bus.far_beat_ack && (!burst_r || beat_r == BURST_LAST);

  // main tenure sequencer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= HBP_IDLE;
      beat_r <= BEAT_RST;
      burst_r <= 1'b0;
      write_r <= 1'b0;
    end else begin
      unique case (state_r)
        HBP_IDLE: begin
          beat_r <= BEAT_RST;
          if (bus.far_transfer_start_strobe) begin // R12
            burst_r <= bus.far_burst_flag; // R8
            write_r <= bus.far_transfer_type_code == TT_WRITE;
            if (bus.ext_addr_start || unsupported) begin
              state_r <= HBP_IDLE; // no data tenure on error
            end else if (bus.local_slave_claim) begin
              state_r <= HBP_CLAIM; // R4
            end else begin
              state_r <= HBP_DATA;
            end
          end else if (i_snoop_req) begin
            state_r <= HBP_SNOOP; // R11
          end
        end
        HBP_DATA: begin
          if (ack_r) begin
            beat_r <= beat_r + 2'h1;
            if (!burst_r || beat_r == BURST_LAST) begin
              state_r <= HBP_IDLE; // R6
            end
          end
        end
        HBP_CLAIM: begin
          if (bus.far_beat_ack) begin // R7
            beat_r <= beat_r + 2'h1;
            if (far_last) begin
              state_r <= HBP_IDLE;
            end
          end
        end
        HBP_SNOOP: begin
          state_r <= HBP_IDLE; // broadcast only, no data tenure
        end
      endcase
    end
  end

  // beat acknowledge: one beat per cycle in the data state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_r <= 1'b0;
    end else begin
      // drop after the final beat so the tenure is not overrun
      ack_r <= state_r == HBP_DATA &&
        !(ack_r && (!burst_r || beat_r == BURST_LAST)) &&
        !(ack_r && beat_r == BURST_LAST - 2'h1 && !burst_r); // R6
    end
  end

  // error acknowledge, one-cycle pulse after the offending start
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err_r <= 1'b0;
    end else begin
      err_r <= i_err_ack_en && state_r == HBP_IDLE && // R17
        bus.far_transfer_start_strobe &&
        (bus.ext_addr_start || unsupported); // R9 R10 R16
    end
  end

  // machine check stays asserted while the fault persists
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mcp_r <= 1'b0;
    end else begin
      mcp_r <= i_fatal_err; // R5
    end
  end

  // snoop address latched so the bus sees a stable value
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      snoop_addr_r <= '0;
      snoop_wr_r <= 1'b0;
    end else if (state_r == HBP_IDLE && i_snoop_req) begin
      snoop_addr_r <= i_snoop_addr;
      snoop_wr_r <= i_snoop_wr;
    end
  end

  // captured request and write data toward the memory side
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_req_valid <= 1'b0;
      o_req_addr <= '0;
      o_req_size <= SIZE_8B;
      o_req_type <= '0;
      o_req_burst <= 1'b0;
      o_req_global <= 1'b0;
      o_req_wt <= 1'b0;
      o_wr_valid <= 1'b0;
      o_wr_data <= '0;
    end else begin
      o_req_valid <= state_r == HBP_IDLE && bus.far_transfer_start_strobe;
      if (state_r == HBP_IDLE && bus.far_transfer_start_strobe) begin
        o_req_addr <= bus.far_addr; // R12
        o_req_size <= bus.far_transfer_size_code; // R13
        o_req_type <= bus.far_transfer_type_code; // R14
        o_req_burst <= bus.far_burst_flag; // R8
        o_req_global <= bus.far_global_oe && bus.far_global_flag; // R3
        o_req_wt <= bus.far_write_through_oe && // R15
          bus.far_write_through_flag;
      end
      o_wr_valid <= state_r == HBP_DATA && write_r && ack_r;
      if (state_r == HBP_DATA && write_r && ack_r) begin
        o_wr_data <= {bus.far_data_high_half, bus.far_data_low_half}; // R1
      end
    end
  end

  // bus drive: data only for device-sourced reads
  assign bus.dev_data_high_half = i_rd_data[DATA_W-1:HALF_W]; // R1
  assign bus.dev_data_low_half = i_rd_data[HALF_W-1:0];
  assign bus.dev_data_oe = state_r == HBP_DATA && !write_r && ack_r; // R2
  assign bus.dev_beat_ack = ack_r;
  assign bus.dev_beat_ack_oe = state_r == HBP_DATA; // R4
  assign bus.dev_transfer_start_strobe = state_r == HBP_SNOOP; // R11
  assign bus.dev_attr_oe = state_r == HBP_SNOOP;
  assign bus.dev_addr = snoop_addr_r;
  assign bus.dev_transfer_size_code = SIZE_8B;
  assign bus.dev_transfer_type_code = snoop_wr_r ? TT_SNOOP_WR : TT_SNOOP_RD;
  assign bus.dev_burst_flag = 1'b1; // snoops cover a cache line
  assign bus.dev_global_flag = 1'b1; // R3
  assign bus.dev_global_oe = state_r == HBP_SNOOP;
  assign bus.dev_write_through_flag = 1'b0; // R15
  assign bus.dev_write_through_oe = state_r == HBP_SNOOP;
  assign bus.transfer_error_ack = err_r; // R9
  assign bus.fatal_error_alert = mcp_r; // R5
  assign o_snoop_busy = state_r != HBP_IDLE;
  assign o_err = err_r;
endmodule : hbp_dev_port

//--- rtl/hbp_far_port.sv
`timescale 1ns/1ns
// far-end agent: a bus master that may also act as claiming local slave
module hbp_far_port (
  input wire logic i_clk,
  input wire logic i_rst_b,
  hbp_bus_if.far bus,
  input wire logic i_start,
  input wire logic [hbp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [hbp_pkg::SIZE_W-1:0] i_size,
  input wire logic [hbp_pkg::TYPE_W-1:0] i_type,
  input wire logic i_burst,
  input wire logic i_global,
  input wire logic i_wt,
  input wire logic i_ext_start,
  input wire logic i_claim,
  input wire logic [hbp_pkg::DATA_W-1:0] i_wr_data,
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  output logic o_mcp,
  output logic o_snoop_seen,
  output logic [hbp_pkg::ADDR_W-1:0] o_snoop_addr,
  output logic [hbp_pkg::DATA_W-1:0] o_rd_data
);
  import hbp_pkg::*;

  typedef enum logic [2:0] {
    HBF_IDLE = 3'h1, // ready for a request
    HBF_ADDR = 3'h2, // start strobe and attributes on the bus
    HBF_DATA = 3'h4 // data tenure in progress
  } hbf_state_t;

  hbf_state_t state_r;
  logic [ADDR_W-1:0] addr_r;
  logic [SIZE_W-1:0] size_r;
  logic [TYPE_W-1:0] type_r;
  logic burst_r, global_r, wt_r, ext_r, claim_r, write_r;
  logic [1:0] beat_r;
  logic ack_any;
  logic last;

  // whoever answers the beat, device or this end as claiming slave
  assign ack_any = (bus.dev_beat_ack_oe && bus.dev_beat_ack) ||
    (claim_r && state_r == HBF_DATA);
  assign last = !burst_r || beat_r == BURST_LAST;

  // request sequencer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= HBF_IDLE;
      beat_r <= BEAT_RST;
      o_done <= 1'b0;
      o_error <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_error <= 1'b0;
      unique case (state_r)
        HBF_IDLE: begin
          beat_r <= BEAT_RST;
          if (i_start) begin
            state_r <= HBF_ADDR;
          end
        end
        HBF_ADDR: begin
          // unsupported starts get no data tenure
          state_r <= (ext_r || type_r == TT_GFX_RD || type_r == TT_GFX_WR)
            ? HBF_IDLE : HBF_DATA;
          o_done <= ext_r || type_r == TT_GFX_RD || type_r == TT_GFX_WR;
        end
        HBF_DATA: begin
          if (bus.transfer_error_ack) begin
            state_r <= HBF_IDLE; // error ends the transfer at once
            o_error <= 1'b1;
            o_done <= 1'b1;
          end else if (ack_any) begin // R7
            beat_r <= beat_r + 2'h1;
            if (last) begin
              state_r <= HBF_IDLE;
              o_done <= 1'b1;
            end
          end
        end
        default: state_r <= HBF_IDLE;
      endcase
      if (bus.transfer_error_ack) begin
        o_error <= 1'b1;
      end
    end
  end

  // attributes captured at request time so they stay stable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_r <= '0;
      size_r <= SIZE_8B;
      type_r <= '0;
      {burst_r, global_r, wt_r, ext_r, claim_r, write_r} <= '0;
    end else if (state_r == HBF_IDLE && i_start) begin
      addr_r <= i_addr;
      size_r <= i_size;
      type_r <= i_type;
      burst_r <= i_burst;
      global_r <= i_global;
      wt_r <= i_wt;
      ext_r <= i_ext_start;
      claim_r <= i_claim;
      write_r <= i_type == TT_WRITE;
    end
  end

  // read data, snoop observation and machine check
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= '0;
      o_snoop_seen <= 1'b0;
      o_snoop_addr <= '0;
      o_mcp <= 1'b0;
    end else begin
      if (bus.dev_data_oe) begin
        o_rd_data <= {bus.dev_data_high_half, bus.dev_data_low_half};
      end
      o_snoop_seen <= bus.dev_transfer_start_strobe;
      if (bus.dev_transfer_start_strobe) begin
        o_snoop_addr <= bus.dev_addr;
      end
      o_mcp <= bus.fatal_error_alert;
    end
  end

  assign bus.far_transfer_start_strobe = state_r == HBF_ADDR; // R12
  assign bus.far_attr_oe = state_r == HBF_ADDR;
  assign bus.far_addr = addr_r;
  assign bus.far_transfer_size_code = size_r;
  assign bus.far_transfer_type_code = type_r;
  assign bus.far_burst_flag = burst_r;
  assign bus.far_global_flag = global_r;
  assign bus.far_global_oe = state_r == HBF_ADDR;
  assign bus.far_write_through_flag = wt_r;
  assign bus.far_write_through_oe = state_r == HBF_ADDR;
  assign bus.ext_addr_start = state_r == HBF_ADDR && ext_r;
  assign bus.local_slave_claim = state_r == HBF_ADDR && claim_r;
  assign bus.far_data_high_half = i_wr_data[DATA_W-1:HALF_W];
  assign bus.far_data_low_half = i_wr_data[HALF_W-1:0];
  assign bus.far_data_oe = state_r == HBF_DATA && (write_r || claim_r);
  assign bus.far_beat_ack = claim_r && state_r == HBF_DATA;
  assign bus.far_beat_ack_oe = claim_r && state_r == HBF_DATA;
  assign o_busy = state_r != HBF_IDLE;
endmodule : hbp_far_port

//--- verif/hbp_chk.sv
`timescale 1ns/1ns
// watches the shared bus between the bridge end and the far agent
module hbp_chk (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_err_ack_en,
  input wire logic i_fatal_err,
  input wire logic far_transfer_start_strobe,
  input wire logic [hbp_pkg::TYPE_W-1:0] far_transfer_type_code,
  input wire logic ext_addr_start,
  input wire logic local_slave_claim,
  input wire logic transfer_error_ack,
  input wire logic fatal_error_alert,
  input wire logic dev_beat_ack,
  input wire logic dev_beat_ack_oe,
  input wire logic dev_data_oe,
  input wire logic far_data_oe,
  input wire logic dev_transfer_start_strobe,
  input wire logic dev_attr_oe,
  input wire logic [hbp_pkg::TYPE_W-1:0] dev_transfer_type_code
);
  import hbp_pkg::*;
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic gfx; // graphics type, never served by the bridge
  logic unsup; // far start that must end without a data tenure
  assign gfx = far_transfer_type_code == TT_GFX_RD ||
    far_transfer_type_code == TT_GFX_WR;
  assign unsup = far_transfer_start_strobe && (ext_addr_start || gfx);

  a_ext_err_ack: assert property (far_transfer_start_strobe &&
    ext_addr_start && i_err_ack_en |=> transfer_error_ack)
    else $error("no error ack after extended start");
  a_gfx_err_ack: assert property (far_transfer_start_strobe && gfx &&
    i_err_ack_en |=> transfer_error_ack)
    else $error("no error ack after graphics access");
  a_err_gated_off: assert property (!i_err_ack_en &&
    !$past(i_err_ack_en) |-> !transfer_error_ack)
    else $error("error ack while disabled");
  a_err_one_cycle: assert property (transfer_error_ack |=>
    !transfer_error_ack)
    else $error("error ack longer than a cycle");
  a_err_no_beats: assert property (unsup |=>
    (!dev_beat_ack_oe)[*4])
    else $error("data tenure after refused start");
  a_claim_silent: assert property (far_transfer_start_strobe &&
    local_slave_claim |=> (!dev_beat_ack_oe && !dev_beat_ack)[*6])
    else $error("bridge acked a claimed transfer");
  a_beat_ack_due: assert property (far_transfer_start_strobe &&
    !unsup && !local_slave_claim |-> ##[1:4] dev_beat_ack)
    else $error("no beat ack after served start");
  a_one_data_drv: assert property (dev_data_oe |-> !far_data_oe)
    else $error("both ends drive the data bus");
  a_snoop_only: assert property (dev_transfer_start_strobe |->
    dev_attr_oe && (dev_transfer_type_code == TT_SNOOP_RD ||
    dev_transfer_type_code == TT_SNOOP_WR))
    else $error("bridge start is not a snoop broadcast");
  a_fatal_follow: assert property ($past(i_rst_b) |->
    fatal_error_alert == $past(i_fatal_err))
    else $error("fatal alert does not follow its cause");
  a_start_pulse: assert property (far_transfer_start_strobe |=>
    !far_transfer_start_strobe)
    else $error("far start strobe longer than a cycle");
endmodule // hbp_chk

//--- verif/tb_host_processor_bus_port.sv
`timescale 1ns/1ns
// both ends joined by the bus; the bench drives their user sides
module tb_host_processor_bus_port;
  import hbp_pkg::*;
  logic i_clk = 1'b0; // 125 MHz
  logic i_rst_b = 1'b0;
  logic err_en = 1'b1; // error ack enable
  logic fatal = 1'b0;
  logic sn_req = 1'b0;
  logic [31:0] sn_addr = 32'h0;
  logic sn_wr = 1'b0;
  logic [63:0] rd_data = 64'h0;
  logic start = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [2:0] size = SIZE_8B;
  logic [4:0] ttype = TT_READ;
  logic burst = 1'b0;
  logic glb = 1'b0;
  logic wt = 1'b0;
  logic ext = 1'b0;
  logic claim = 1'b0;
  logic [63:0] wr_data = 64'h0;
  logic req_valid, req_global, req_wt, wr_valid, d_err, f_done, f_error;
  logic f_mcp, f_sn_seen;
  logic req_burst, burst_cap, sn_busy, f_busy; // burst and busy views
  logic [31:0] req_addr, f_sn_addr;
  logic [2:0] req_size;
  logic [4:0] req_type;
  logic [63:0] d_wr_data, f_rd_data;
  // tallies of one transfer, cleared before each
  int dev_acks, far_acks, wr_n, errs, ferrs, dones, sn_n;
  logic [41:0] req_cap; // attributes the bridge handed on
  logic [63:0] wr_cap;
  logic [31:0] hi_cap, sn_cap;
  logic [4:0] dtype; // type of the last bridge start
  int fails = 0;
  int n_compared = 0;

  always #4 i_clk = ~i_clk;

  hbp_bus_if bus ();
  hbp_dev_port hbp_dev_port_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .bus(bus.dev), .i_err_ack_en(err_en), .i_fatal_err(fatal),
    .i_snoop_req(sn_req), .i_snoop_addr(sn_addr), .i_snoop_wr(sn_wr),
    .i_rd_data(rd_data), .o_snoop_busy(sn_busy), .o_req_valid(req_valid),
    .o_req_addr(req_addr), .o_req_size(req_size), .o_req_type(req_type),
    .o_req_burst(req_burst), .o_req_global(req_global), .o_req_wt(req_wt),
    .o_wr_valid(wr_valid), .o_wr_data(d_wr_data), .o_err(d_err));
  hbp_far_port hbp_far_port_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .bus(bus.far), .i_start(start), .i_addr(addr), .i_size(size),
    .i_type(ttype), .i_burst(burst), .i_global(glb), .i_wt(wt),
    .i_ext_start(ext), .i_claim(claim), .i_wr_data(wr_data),
    .o_busy(f_busy),
    .o_done(f_done), .o_error(f_error), .o_mcp(f_mcp),
    .o_snoop_seen(f_sn_seen), .o_snoop_addr(f_sn_addr),
    .o_rd_data(f_rd_data));
  hbp_chk hbp_chk_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_err_ack_en(err_en), .i_fatal_err(fatal),
    .far_transfer_start_strobe(bus.far_transfer_start_strobe),
    .far_transfer_type_code(bus.far_transfer_type_code),
    .ext_addr_start(bus.ext_addr_start),
    .local_slave_claim(bus.local_slave_claim),
    .transfer_error_ack(bus.transfer_error_ack),
    .fatal_error_alert(bus.fatal_error_alert),
    .dev_beat_ack(bus.dev_beat_ack), .dev_beat_ack_oe(bus.dev_beat_ack_oe),
    .dev_data_oe(bus.dev_data_oe), .far_data_oe(bus.far_data_oe),
    .dev_transfer_start_strobe(bus.dev_transfer_start_strobe),
    .dev_attr_oe(bus.dev_attr_oe),
    .dev_transfer_type_code(bus.dev_transfer_type_code));

  // sample what both ends show, once settled at each rising edge
  always @(posedge i_clk) begin
    if (bus.dev_beat_ack === 1'b1) dev_acks++;
    if (bus.far_beat_ack === 1'b1) far_acks++;
    if (bus.far_data_oe === 1'b1) hi_cap = bus.far_data_high_half;
    if (bus.dev_transfer_start_strobe === 1'b1)
      dtype = bus.dev_transfer_type_code;
    if (wr_valid === 1'b1) wr_n++;
    if (wr_valid === 1'b1) wr_cap = d_wr_data;
    if (req_valid === 1'b1)
      req_cap = {req_addr, req_size, req_type, req_global, req_wt};
    if (req_valid === 1'b1) burst_cap = req_burst;
    if (d_err === 1'b1) errs++;
    if (f_error === 1'b1) ferrs++;
    if (f_done === 1'b1) dones++;
    if (f_sn_seen === 1'b1) sn_cap = f_sn_addr;
    if (f_sn_seen === 1'b1) sn_n++;
  end

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // reset held ten cycles, released off the sampling edge
  task automatic do_reset();
    i_rst_b = 1'b0;
    repeat (10) @(negedge i_clk);
    i_rst_b = 1'b1;
  endtask

  // one far start; waits for done under a bound of 20 cycles; refused
  // transfers end at their address cycle even with error ack disabled
  task automatic xfer(input logic [4:0] t, input logic b, input logic x,
                      input logic c);
    @(negedge i_clk);
    {dev_acks, far_acks, wr_n, errs, ferrs, dones, sn_n} = '0;
    ttype = t;
    burst = b;
    ext = x;
    claim = c;
    start = 1'b1;
    @(negedge i_clk);
    start = 1'b0;
    chk_flag(f_busy, 1'b1);
    for (int k = 0; k < 20 && dones == 0; k++) @(negedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic t_read();
    addr = 32'h0000_1040;
    glb = 1'b1;
    wt = 1'b1;
    rd_data = 64'h0123_4567_89ab_cdef;
    xfer(TT_READ, 1'b0, 1'b0, 1'b0);
    chk_val(f_rd_data, rd_data);
    chk_val(64'(dev_acks), 64'h1);
    chk_flag(burst_cap, 1'b0);
    chk_val(64'(req_cap), 64'({addr, SIZE_8B, TT_READ, 2'h3}));
    $display("test single read done");
  endtask

  task automatic t_wr_burst();
    glb = 1'b0;
    wt = 1'b0;
    wr_data = 64'hfedc_ba98_7654_3210;
    xfer(TT_WRITE, 1'b1, 1'b0, 1'b0);
    chk_val(64'(wr_n), 64'h4);
    chk_flag(burst_cap, 1'b1);
    chk_val(64'(dev_acks), 64'h4);
    chk_val(wr_cap, wr_data);
    chk_val(64'(hi_cap), 64'(wr_data[63:32]));
    chk_val(64'(req_cap), 64'({addr, SIZE_8B, TT_WRITE, 2'h0}));
    $display("test burst write done");
  endtask

  task automatic t_claim();
    size = SIZE_4B;
    xfer(TT_READ, 1'b0, 1'b0, 1'b1);
    chk_val(64'(dev_acks), 64'h0);
    chk_val(64'(far_acks), 64'h1);
    chk_val(64'(req_cap[9:7]), 64'(SIZE_4B));
    $display("test claimed read done");
  endtask

  // refused starts, then an extended start with error ack disabled
  task automatic t_refused();
    xfer(TT_READ, 1'b0, 1'b1, 1'b0);
    chk_val(64'(errs), 64'h1);
    xfer(TT_GFX_RD, 1'b0, 1'b0, 1'b0);
    chk_val(64'(errs), 64'h1);
    xfer(TT_GFX_WR, 1'b0, 1'b0, 1'b0);
    chk_val(64'(ferrs), 64'h1);
    chk_val(64'(dev_acks), 64'h0);
    err_en = 1'b0;
    xfer(TT_READ, 1'b0, 1'b1, 1'b0);
    chk_val(64'(errs), 64'h0);
    err_en = 1'b1;
    do_reset(); // reset both ends; neither is left waiting for an answer
    $display("test refused starts done");
  endtask

  task automatic t_snoop();
    for (int w = 0; w < 2; w++) begin
      sn_n = 0;
      sn_addr = 32'h0002_0100 + 32'(w);
      sn_wr = w[0];
      sn_req = 1'b1;
      @(negedge i_clk);
      chk_flag(sn_busy, 1'b1);
      sn_req = 1'b0;
      for (int k = 0; k < 10 && sn_n == 0; k++) @(negedge i_clk);
      chk_val(64'(sn_cap), 64'(sn_addr));
      chk_val(64'(dtype), 64'(w ? TT_SNOOP_WR : TT_SNOOP_RD));
    end
    $display("test snoop broadcast done");
  endtask

  task automatic t_fatal();
    fatal = 1'b1;
    repeat (2) @(negedge i_clk);
    chk_flag(f_mcp, 1'b1);
    fatal = 1'b0;
    repeat (2) @(negedge i_clk);
    chk_flag(f_mcp, 1'b0);
    $display("test fatal alert done");
  endtask

  // watchdog: the tests need well under 600 cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  initial begin
    do_reset();
    t_read();
    t_wr_burst();
    t_claim();
    t_refused();
    t_snoop();
    t_fatal();
    results();
  end
endmodule // tb_host_processor_bus_port
